// file: rst_supply_map.svh
// register map, field positions, reset values and timing counts for the reset and supply manager
`ifndef RST_SUPPLY_MAP_SVH
`define RST_SUPPLY_MAP_SVH

// byte offsets on the register bus
`define OFF_CLOCK_CONTROL 12'h000
`define OFF_RESET_CAUSE 12'h004
`define OFF_POWER_CONTROL 12'h008
`define OFF_IRQ_STATUS 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_BOOT_VECTOR 12'h014

// clock_control_reg fields
`define CCR_HALT_ENABLE 0
`define CCR_SOFT_ALLOW 1
`define CCR_SOFT_TRIGGER 2

// reset_cause_flags_reg fields
`define CFR_SOFT 0
`define CFR_WDOG 1
`define CFR_WAKE 2
`define CFR_RTC 3
`define CFR_W 4

// power_control_reg fields
`define PCR_LP_IN_WAIT 0
`define PCR_MAIN_STABLE 1
`define PCR_LP_REG_OFF 2
`define PCR_LP_DET_OFF 3
`define PCR_BACKUP_BYPASS 4

// interrupt status bits
`define IRQ_MAIN_STABLE 0
`define IRQ_UV_EVENT 1
`define IRQ_W 2

// release stretch
`define REF_CYCLES 12'd2048
`define HALF_CYCLES 12'd8
`define RELEASE_CNT 12'd2064
`define CNT_W 12
`define SETTLE_CNT 8'd64
`define VECTOR_ADDR 32'h0000_0000

`endif

// file: rst_supply_pkg.sv
// types shared by the reset and supply manager
package rst_supply_pkg;
  typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} rst_state_t;
endpackage

// file: rst_supply_mgr.sv
// reset gathering, release stretch, cause flags and regulator control
`include "rst_supply_map.svh"
`timescale 1ns/1ps
`default_nettype none

module rst_supply_mgr (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // reset sources
  input wire logic EXT_RESET_PIN_N,
  input wire logic UV_MAIN_LOW,
  input wire logic UV_BACKUP_LOW,
  input wire logic WDOG_EXPIRED,
  input wire logic WAKE_PIN,
  input wire logic RTC_ALARM,
  // power state
  input wire logic STANDBY,
  input wire logic WAIT_FOR_IRQ,
  input wire logic MAIN_REG_SETTLED,
  input wire logic BACKUP_SUPPLY_PRESENT,
  // reset outputs
  output logic SYS_RESET_N,
  output logic IO_RESET_N,
  output logic PC_LOAD,
  output logic [31:0] PC_VECTOR_ADDR,
  // regulator and clock control
  output logic MAIN_REG_ON,
  output logic LP_REG_ON,
  output logic LP_REG_BYPASS,
  output logic UV_MAIN_EN,
  output logic UV_BACKUP_EN,
  output logic DOMAIN_SWITCH_ON,
  output logic PLL_EN,
  output logic SLOW_CLK_LIMIT,
  output logic HALF_REF_CLOCK_EN,
  // interrupt
  output logic IRQ
);

  rst_supply_pkg::rst_state_t state_reg;
  logic [`CNT_W-1:0] cnt_reg;
  logic half_reg;
  logic [7:0] settle_reg;
  logic halt_en_reg;
  logic soft_allow_reg;
  logic soft_req_reg;
  logic [`CFR_W-1:0] cause_reg;
  logic lp_in_wait_reg;
  logic lp_off_reg;
  logic lp_det_off_reg;
  logic bypass_reg;
  logic stable_reg;
  logic [`IRQ_W-1:0] irq_stat_reg;
  logic [`IRQ_W-1:0] irq_mask_reg;
  logic [`IRQ_W-1:0] irq_set;
  logic main_on;
  logic uv_any;
  logic wdog_src;
  logic wake_src;
  logic rtc_src;
  logic any_src;
  logic pin_rst;
  logic wr;
  logic rd;
  logic stable_prev_reg;

  // pin reset acts combinationally into the reset chain, with no clock needed
  assign pin_rst = ~EXT_RESET_PIN_N;
  assign uv_any = UV_MAIN_LOW | (UV_BACKUP_LOW & ~lp_det_off_reg);
  assign wdog_src = WDOG_EXPIRED;
  assign wake_src = STANDBY & WAKE_PIN;
  assign rtc_src = STANDBY & RTC_ALARM;
  // assumed: pin held low through supply ramp, so no power-on detector here
  assign any_src = pin_rst | uv_any | wdog_src | wake_src | rtc_src | soft_req_reg;
  assign main_on = ~STANDBY & ~(lp_in_wait_reg & WAIT_FOR_IRQ);
  assign wr = PSEL & PENABLE & PWRITE;
  assign rd = PSEL & ~PWRITE;

  // release sequencer; the half-rate enable toggles every cycle whenever no reset source or RST_N is active
  always_ff @(posedge CORE_CLK or posedge pin_rst) begin
    if (pin_rst) begin
      state_reg <= rst_supply_pkg::ST_HOLD;
      cnt_reg <= '0;
      half_reg <= 1'b0;
    end else if (!RST_N || any_src) begin
      state_reg <= rst_supply_pkg::ST_HOLD;
      cnt_reg <= '0;
      half_reg <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      case (state_reg)
        rst_supply_pkg::ST_HOLD: begin
          // one extra cycle here covers synchronising the release edge
          state_reg <= rst_supply_pkg::ST_STRETCH;
          cnt_reg <= '0;
        end
        rst_supply_pkg::ST_STRETCH: begin
          if (cnt_reg == `RELEASE_CNT - 12'd1) begin
            state_reg <= rst_supply_pkg::ST_RUN;
          end
          cnt_reg <= cnt_reg + 12'd1;
        end
        default: begin
          state_reg <= rst_supply_pkg::ST_RUN;
        end
      endcase
    end
  end

  // reset and start outputs
  always_ff @(posedge CORE_CLK or posedge pin_rst) begin
    if (pin_rst) begin
      SYS_RESET_N <= 1'b0;
      IO_RESET_N <= 1'b0;
      PC_LOAD <= 1'b0;
      HALF_REF_CLOCK_EN <= 1'b0;
    end else if (!RST_N) begin
      SYS_RESET_N <= 1'b0;
      IO_RESET_N <= 1'b0;
      PC_LOAD <= 1'b0;
      HALF_REF_CLOCK_EN <= 1'b0;
    end else begin
      SYS_RESET_N <= (state_reg == rst_supply_pkg::ST_RUN) && !any_src;
      IO_RESET_N <= (state_reg == rst_supply_pkg::ST_RUN) && !any_src;
      PC_LOAD <= (state_reg == rst_supply_pkg::ST_STRETCH) &&
                 (cnt_reg == `RELEASE_CNT - 12'd1) && !any_src;
      HALF_REF_CLOCK_EN <= half_reg;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    PC_VECTOR_ADDR <= `VECTOR_ADDR;
  end

  // cause flags survive soft, watchdog, wake and alarm resets; pin, RST_N or undervoltage clears them
  always_ff @(posedge CORE_CLK or posedge pin_rst) begin
    if (pin_rst) begin
      cause_reg <= '0;
    end else if (!RST_N || uv_any) begin
      cause_reg <= '0;
    end else if (state_reg == rst_supply_pkg::ST_RUN && any_src) begin
      cause_reg <= '0;
      cause_reg[`CFR_SOFT] <= soft_req_reg;
      cause_reg[`CFR_WDOG] <= wdog_src;
      cause_reg[`CFR_WAKE] <= wake_src;
      cause_reg[`CFR_RTC] <= rtc_src;
    end
  end

  // clock control register; the trigger self-clears once reset begins
  always_ff @(posedge CORE_CLK or posedge pin_rst) begin
    if (pin_rst) begin
      halt_en_reg <= 1'b0;
      soft_allow_reg <= 1'b0;
      soft_req_reg <= 1'b0;
    end else if (!RST_N) begin
      halt_en_reg <= 1'b0;
      soft_allow_reg <= 1'b0;
      soft_req_reg <= 1'b0;
    end else if (state_reg != rst_supply_pkg::ST_RUN) begin
      soft_req_reg <= 1'b0;
    end else if (wr && PADDR == `OFF_CLOCK_CONTROL) begin
      halt_en_reg <= PWDATA[`CCR_HALT_ENABLE];
      soft_allow_reg <= PWDATA[`CCR_SOFT_ALLOW];
      soft_req_reg <= PWDATA[`CCR_SOFT_TRIGGER] && halt_en_reg && soft_allow_reg;
    end
  end

  // power control register
  always_ff @(posedge CORE_CLK or posedge pin_rst) begin
    if (pin_rst) begin
      lp_in_wait_reg <= 1'b0;
      lp_off_reg <= 1'b0;
      lp_det_off_reg <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (!RST_N) begin
      lp_in_wait_reg <= 1'b0;
      lp_off_reg <= 1'b0;
      lp_det_off_reg <= 1'b0;
      bypass_reg <= 1'b0;
    end else if (wr && PADDR == `OFF_POWER_CONTROL) begin
      lp_in_wait_reg <= PWDATA[`PCR_LP_IN_WAIT];
      // low-power regulator may only go off with backup supply there
      lp_off_reg <= PWDATA[`PCR_LP_REG_OFF] && BACKUP_SUPPLY_PRESENT;
      bypass_reg <= PWDATA[`PCR_BACKUP_BYPASS] && BACKUP_SUPPLY_PRESENT;
      lp_det_off_reg <= PWDATA[`PCR_LP_DET_OFF] && PWDATA[`PCR_LP_REG_OFF] &&
                        BACKUP_SUPPLY_PRESENT;
    end
  end

  // settle timer; flag only after regulator on and reporting settled
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !main_on || !MAIN_REG_SETTLED) begin
      settle_reg <= '0;
      stable_reg <= 1'b0;
    end else if (settle_reg == `SETTLE_CNT) begin
      stable_reg <= 1'b1;
    end else begin
      settle_reg <= settle_reg + 8'd1;
    end
  end

  // regulator, detector and domain outputs
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || pin_rst) begin
      MAIN_REG_ON <= 1'b1;
      LP_REG_ON <= 1'b1;
      LP_REG_BYPASS <= 1'b0;
      UV_MAIN_EN <= 1'b1;
      UV_BACKUP_EN <= 1'b1;
      DOMAIN_SWITCH_ON <= 1'b1;
      PLL_EN <= 1'b0;
      SLOW_CLK_LIMIT <= 1'b1;
    end else begin
      MAIN_REG_ON <= main_on;
      LP_REG_ON <= ~lp_off_reg;
      LP_REG_BYPASS <= bypass_reg;
      UV_MAIN_EN <= 1'b1;
      UV_BACKUP_EN <= ~(lp_det_off_reg & lp_off_reg);
      DOMAIN_SWITCH_ON <= ~STANDBY;
      PLL_EN <= main_on & stable_reg;
      SLOW_CLK_LIMIT <= ~main_on;
    end
  end

  // interrupts: stable rising edge and undervoltage event; set beats clear
  assign irq_set = {uv_any, stable_reg & ~stable_prev_reg};

  // pin reset must also restore mask and status to their reset values
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || pin_rst) begin
      stable_prev_reg <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
    end else begin
      stable_prev_reg <= stable_reg;
      if (wr && PADDR == `OFF_IRQ_STATUS) begin
        irq_stat_reg <= (irq_stat_reg & ~PWDATA[`IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat_reg <= irq_stat_reg | irq_set;
      end
      if (wr && PADDR == `OFF_IRQ_MASK) begin
        irq_mask_reg <= PWDATA[`IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || pin_rst) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // apb: zero wait; read data registered in setup cycle, unmapped reads zero with error
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL & ~PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
      if (PSEL && !PENABLE) begin
        if (PADDR == `OFF_CLOCK_CONTROL) begin
          PRDATA[`CCR_HALT_ENABLE] <= halt_en_reg;
          PRDATA[`CCR_SOFT_ALLOW] <= soft_allow_reg;
        end else if (PADDR == `OFF_RESET_CAUSE) begin
          PRDATA[`CFR_W-1:0] <= cause_reg;
        end else if (PADDR == `OFF_POWER_CONTROL) begin
          PRDATA[`PCR_LP_IN_WAIT] <= lp_in_wait_reg;
          PRDATA[`PCR_MAIN_STABLE] <= stable_reg;
          PRDATA[`PCR_LP_REG_OFF] <= lp_off_reg;
          PRDATA[`PCR_LP_DET_OFF] <= lp_det_off_reg;
          PRDATA[`PCR_BACKUP_BYPASS] <= bypass_reg;
        end else if (PADDR == `OFF_IRQ_STATUS) begin
          PRDATA[`IRQ_W-1:0] <= irq_stat_reg;
        end else if (PADDR == `OFF_IRQ_MASK) begin
          PRDATA[`IRQ_W-1:0] <= irq_mask_reg;
        end else if (PADDR == `OFF_BOOT_VECTOR) begin
          PRDATA <= `VECTOR_ADDR;
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

endmodule

`default_nettype wire

// file: rst_supply_mgr_checker.sv
// port assertions for the reset and supply manager
`timescale 1ns/1ps
`default_nettype none
module rst_supply_mgr_checker (
  // clock and sources
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic EXT_RESET_PIN_N,
  input wire logic UV_MAIN_LOW,
  input wire logic UV_BACKUP_LOW,
  input wire logic WDOG_EXPIRED,
  input wire logic WAKE_PIN,
  input wire logic RTC_ALARM,
  input wire logic STANDBY,
  // watched outputs
  input wire logic SYS_RESET_N,
  input wire logic IO_RESET_N,
  input wire logic PC_LOAD,
  input wire logic [31:0] PC_VECTOR_ADDR,
  input wire logic MAIN_REG_ON,
  input wire logic LP_REG_ON,
  input wire logic UV_MAIN_EN,
  input wire logic UV_BACKUP_EN,
  input wire logic DOMAIN_SWITCH_ON,
  input wire logic PLL_EN,
  input wire logic SLOW_CLK_LIMIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic [11:0] quiet_reg;
  wire uv_src = UV_MAIN_LOW || (UV_BACKUP_LOW && UV_BACKUP_EN);
  wire any_src = !EXT_RESET_PIN_N || uv_src || WDOG_EXPIRED
    || (STANDBY && (WAKE_PIN || RTC_ALARM));
  // saturates so a stuck reset cannot wrap into the window
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || any_src || SYS_RESET_N)
      quiet_reg <= 12'h0;
    else if (quiet_reg != 12'hfff)
      quiet_reg <= quiet_reg + 12'h1;
  end
  a_pin_holds: assert property (!EXT_RESET_PIN_N |-> !SYS_RESET_N && !IO_RESET_N)
    else $error("pin low, reset released");
  a_uv_holds: assert property (uv_src |=> !SYS_RESET_N)
    else $error("undervoltage without reset");
  a_stretch_len: assert property ($rose(SYS_RESET_N) |-> quiet_reg >= 12'h810 && quiet_reg <= 12'h818)
    else $error("release count wrong");
  a_vector_load: assert property ($rose(SYS_RESET_N) |-> $past(PC_LOAD) && PC_VECTOR_ADDR == 32'h0)
    else $error("no vector load");
  a_main_det: assert property (UV_MAIN_EN)
    else $error("main detector off");
  a_pll_off: assert property (!MAIN_REG_ON [*2] |-> !PLL_EN && SLOW_CLK_LIMIT)
    else $error("pll on without main regulator");
  a_standby_off: assert property (STANDBY [*3] |-> !MAIN_REG_ON && !DOMAIN_SWITCH_ON)
    else $error("standby left supplies on");
  a_lp_det: assert property (!UV_BACKUP_EN |-> !LP_REG_ON)
    else $error("detector off, regulator on");
  cover property ($rose(SYS_RESET_N));
  cover property (STANDBY && WAKE_PIN);
  cover property (!UV_BACKUP_EN);
endmodule
bind rst_supply_mgr rst_supply_mgr_checker u_rst_supply_mgr_checker (
  .CORE_CLK, .RST_N, .EXT_RESET_PIN_N, .UV_MAIN_LOW, .UV_BACKUP_LOW, .WDOG_EXPIRED,
  .WAKE_PIN, .RTC_ALARM, .STANDBY, .SYS_RESET_N, .IO_RESET_N, .PC_LOAD, .PC_VECTOR_ADDR,
  .MAIN_REG_ON, .LP_REG_ON, .UV_MAIN_EN, .UV_BACKUP_EN, .DOMAIN_SWITCH_ON, .PLL_EN,
  .SLOW_CLK_LIMIT);
`default_nettype wire

// file: pin_partner.sv
// board reset circuit and standby, wake and alarm lines
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // clock and supply state
  input wire logic clk,
  input wire logic supply_ok,
  // lines into the device
  output logic ext_reset_n,
  output logic standby,
  output logic wake,
  output logic alarm
);
  initial begin
    ext_reset_n = 1'b0;
    standby = 1'b0;
    wake = 1'b0;
    alarm = 1'b0;
    wait (supply_ok === 1'b1);
    @(posedge clk);
    ext_reset_n <= 1'b1;
  end
  // pulse of n clocks; the pin is not filtered, so any length resets the device
  task automatic pin_pulse(input int n);
    ext_reset_n <= 1'b0;
    repeat (n) @(posedge clk);
    ext_reset_n <= 1'b1;
  endtask
  task automatic set_standby(input logic v);
    standby <= v;
  endtask
  task automatic event_pulse(input logic rtc);
    alarm <= rtc;
    wake <= !rtc;
    @(posedge clk);
    alarm <= 1'b0;
    wake <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: rst_supply_mgr_bench.sv
// self-checking bench for the reset and supply manager
`include "rst_supply_map.svh"
`timescale 1ns/1ps
`default_nettype none
module rst_supply_mgr_bench;
  logic CORE_CLK = 1'b0, RST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0, PRDATA, PC_VECTOR_ADDR, rd, d;
  logic UV_MAIN_LOW = 1'b0, UV_BACKUP_LOW = 1'b0, WDOG_EXPIRED = 1'b0, WAIT_FOR_IRQ = 1'b0;
  logic MAIN_REG_SETTLED = 1'b0, BACKUP_SUPPLY_PRESENT = 1'b0, supply_ok = 1'b0, err;
  logic PREADY, PSLVERR, EXT_RESET_PIN_N, WAKE_PIN, RTC_ALARM, STANDBY, SYS_RESET_N;
  logic IO_RESET_N, PC_LOAD, MAIN_REG_ON, LP_REG_ON, LP_REG_BYPASS, UV_MAIN_EN;
  logic UV_BACKUP_EN, DOMAIN_SWITCH_ON, PLL_EN, SLOW_CLK_LIMIT, HALF_REF_CLOCK_EN, IRQ;
  int mismatches = 0, tests_run = 0;
  rst_supply_mgr u_rst_supply_mgr (.CORE_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PWDATA, .PRDATA, .PREADY, .PSLVERR, .EXT_RESET_PIN_N, .UV_MAIN_LOW, .UV_BACKUP_LOW,
    .WDOG_EXPIRED, .WAKE_PIN, .RTC_ALARM, .STANDBY, .WAIT_FOR_IRQ, .MAIN_REG_SETTLED,
    .BACKUP_SUPPLY_PRESENT, .SYS_RESET_N, .IO_RESET_N, .PC_LOAD, .PC_VECTOR_ADDR,
    .MAIN_REG_ON, .LP_REG_ON, .LP_REG_BYPASS, .UV_MAIN_EN, .UV_BACKUP_EN,
    .DOMAIN_SWITCH_ON, .PLL_EN, .SLOW_CLK_LIMIT, .HALF_REF_CLOCK_EN, .IRQ);
  pin_partner u_pin_partner (.clk(CORE_CLK), .supply_ok, .ext_reset_n(EXT_RESET_PIN_N),
    .standby(STANDBY), .wake(WAKE_PIN), .alarm(RTC_ALARM));
  initial forever #5 CORE_CLK = ~CORE_CLK;
  task automatic complete_run;
    $display("tests_run %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CORE_CLK);
      if (++n > 20) begin
        mismatches++;
        complete_run();
      end
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // bounded wait for the system reset to reach a level
  task automatic wait_rst(input logic lvl, input int lim);
    int n;
    n = 0;
    while (SYS_RESET_N !== lvl) begin
      @(posedge CORE_CLK);
      if (++n > lim) begin
        mismatches++;
        complete_run();
      end
    end
  endtask
  function automatic logic [31:0] cause_exp(input int s);
    return 32'h1 << ((s == 0) ? `CFR_WDOG : (s == 1) ? `CFR_WAKE : `CFR_RTC);
  endfunction
  initial begin
    repeat (100000) @(posedge CORE_CLK);
    mismatches++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hb46c));
    repeat (16) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    supply_ok <= 1'b1;
    wait_rst(1'b1, 3000);
    chk(PC_VECTOR_ADDR, 32'h0);
    rchk(`OFF_BOOT_VECTOR, 32'h0);
    rchk(`OFF_RESET_CAUSE, 32'h0);
    rchk(`OFF_POWER_CONTROL, 32'h0);
    rchk(12'h020, 32'h0);
    chk(err, 1'b1);
    repeat (4) begin
      d = $urandom;
      apb(1'b1, `OFF_IRQ_MASK, d);
      rchk(`OFF_IRQ_MASK, d & 32'h3);
    end
    MAIN_REG_SETTLED <= 1'b1;
    repeat (70 + $urandom % 8) @(posedge CORE_CLK);
    rchk(`OFF_POWER_CONTROL, 32'h1 << `PCR_MAIN_STABLE);
    apb(1'b1, `OFF_IRQ_MASK, 32'h1);
    @(posedge CORE_CLK);
    chk(IRQ, 1'b1);
    apb(1'b1, `OFF_IRQ_MASK, 32'h0);
    @(posedge CORE_CLK);
    chk(IRQ, 1'b0);
    apb(1'b1, `OFF_IRQ_STATUS, 32'h1);
    rchk(`OFF_IRQ_STATUS, 32'h0);
    apb(1'b1, `OFF_POWER_CONTROL, 32'hc);
    chk(LP_REG_ON, 1'b1);
    BACKUP_SUPPLY_PRESENT <= 1'b1;
    apb(1'b1, `OFF_POWER_CONTROL, 32'h8);
    chk(UV_BACKUP_EN, 1'b1);
    apb(1'b1, `OFF_POWER_CONTROL, 32'h1c);
    @(posedge CORE_CLK);
    chk({LP_REG_ON, UV_BACKUP_EN, LP_REG_BYPASS}, 3'h1);
    apb(1'b1, `OFF_POWER_CONTROL, 32'h1);
    WAIT_FOR_IRQ <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    chk({MAIN_REG_ON, PLL_EN, SLOW_CLK_LIMIT}, 3'h1);
    WAIT_FOR_IRQ <= 1'b0;
    apb(1'b1, `OFF_CLOCK_CONTROL, 32'h4);
    u_pin_partner.event_pulse(1'b0);
    repeat (3) @(posedge CORE_CLK);
    chk(SYS_RESET_N, 1'b1);
    apb(1'b1, `OFF_CLOCK_CONTROL, 32'h3);
    apb(1'b1, `OFF_CLOCK_CONTROL, 32'h7);
    wait_rst(1'b0, 8);
    wait_rst(1'b1, 3000);
    rchk(`OFF_RESET_CAUSE, 32'h1 << `CFR_SOFT);
    for (int u = 1; u < 3; u++) begin
      {UV_BACKUP_LOW, UV_MAIN_LOW} <= 2'(u);
      repeat (20) @(posedge CORE_CLK);
      chk(SYS_RESET_N, 1'b0);
      {UV_BACKUP_LOW, UV_MAIN_LOW} <= 2'h0;
      wait_rst(1'b1, 3000);
      rchk(`OFF_RESET_CAUSE, 32'h0);
    end
    for (int s = 0; s < 3; s++) begin
      WDOG_EXPIRED <= (s == 0);
      if (s != 0) begin
        u_pin_partner.set_standby(1'b1);
        repeat (4) @(posedge CORE_CLK);
        chk({MAIN_REG_ON, DOMAIN_SWITCH_ON, PLL_EN}, 3'h0);
        u_pin_partner.event_pulse(s == 2);
        u_pin_partner.set_standby(1'b0);
      end
      @(posedge CORE_CLK);
      WDOG_EXPIRED <= 1'b0;
      wait_rst(1'b0, 8);
      wait_rst(1'b1, 3000);
      rchk(`OFF_RESET_CAUSE, cause_exp(s));
    end
    apb(1'b1, `OFF_IRQ_MASK, 32'h3);
    u_pin_partner.pin_pulse(100);
    wait_rst(1'b1, 3000);
    rchk(`OFF_RESET_CAUSE, 32'h0);
    rchk(`OFF_IRQ_MASK, 32'h0);
    complete_run();
  end
endmodule
`default_nettype wire
